// File: hdl/mos_regs.svh
// Purpose: named constants for the management-offload sequencer
// Assumes: included by its bare name
// Notes: counter widths and command codes
`ifndef MOS_REGS_SVH
`define MOS_REGS_SVH
`define MOS_CNT_W 16
`define MOS_DATA_W 8
`define MOS_FIFO_DEPTH 16
`define MOS_CMD_W 3
`define MOS_CMD_NONE 3'h0
`define MOS_CMD_XMIT 3'h1
`define MOS_CMD_RXEN 3'h2
`define MOS_CMD_RXDIS 3'h3
`define MOS_CMD_FORCE 3'h4
`define MOS_CMD_CFG 3'h5
`define MOS_CMD_PHYRD 3'h6
`define MOS_CMD_PHYWR 3'h7
`define MOS_CFG_W 2
`define MOS_CFG_LINK 2'h0
`define MOS_CFG_ADDR 2'h1
`define MOS_CFG_MCAST 2'h2
`define MOS_CFG_UCODE 2'h3
`define MOS_PWR_W 2
`define MOS_PWR_D0 2'h0
`define MOS_ONE 16'h0001
`endif

// File: hdl/mos_pkg.sv
// Purpose: types of the management-offload sequencer
// Assumes: nothing
// Notes: sequencer states
package mos_pkg;
    typedef enum logic [2:0] {
        MOS_IDLE = 3'b000,
        MOS_TXWAIT = 3'b001,
        MOS_TXRUN = 3'b010,
        MOS_RXSEND = 3'b011,
        MOS_RXRECL = 3'b100,
        MOS_ALERT = 3'b101
    } mos_state_type;
endpackage : mos_pkg

// File: hdl/mos_fifo.sv
// Purpose: received management data buffer
// Assumes: one clock, synchronous active-high reset
// Notes: first-word-fall-through, valid/ready on both sides
`timescale 1ns/10ps
module mos_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic flush,
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
    logic [AW:0] count_r, count_nxt;
    logic doWr, doRd;

    assign inReady = (count_r != DEPTH[AW:0]);
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign doWr = inValid && inReady && !flush;
    assign doRd = outValid && outReady && !flush;

    always_comb begin
        wrPtr_nxt = wrPtr_r + AW'(doWr);
        rdPtr_nxt = rdPtr_r + AW'(doRd);
        count_nxt = count_r + (AW+1)'(doWr) - (AW+1)'(doRd);
        if (flush) begin
            wrPtr_nxt = '0;
            rdPtr_nxt = '0;
            count_nxt = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= wrPtr_nxt;
            rdPtr_r <= rdPtr_nxt;
            count_r <= count_nxt;
        end
    end

    // Storage carries no reset, keeps area small
    always_ff @(posedge sys_clk) begin
        if (doWr) begin
            mem[wrPtr_r] <= inData;
        end
    end
endmodule : mos_fifo

// File: hdl/mos_sequencer.sv
// Function
// - Command exchange starts only when no alert is pending
// - D0 forwarding only after receive enable
// - D0 packet: suspend, flag, send, count, reclaim
// - Count every received management packet
// - Transmit waits for DMA, then sets flag
// - Count DMA done, tx done, clear flag
// - Receive flow runs during managed transmit
// - Forward management-only or all filtered packets
// - Alert on power or link change
// - Forced mode held until host or alternate reset
// - Forced entry aborts traffic, discards structures
// - Host bus cycles ignored in forced mode
// - Low power: management packet stops wake matching
// - Disabled reception: wake event only if configured
// - Forced mode counts normal and management receive
// - Forced mode accepts configure and PHY access
// - Alert on packet, low power, PHY read
//
// Purpose: management-offload sequencer between controller and datapath
// Assumes: controller commands arrive as single-cycle pulses
// Notes: alert line is active low, held until controller acknowledges
`timescale 1ns/10ps
`include "mos_regs.svh"
module mos_sequencer
    import mos_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hostBusReset,
    input wire logic alternateResetInput_n,
    input wire logic [`MOS_CMD_W-1:0] cmdCode,
    input wire logic cmdValid,
    input wire logic [`MOS_CFG_W-1:0] cfgSel,
    input wire logic rxAllFiltered,
    input wire logic wakeOnMgmt,
    input wire logic alertAck,
    input wire logic [`MOS_PWR_W-1:0] powerState,
    input wire logic linkUp,
    input wire logic txDmaBusy,
    input wire logic mgmtTxDmaDone,
    input wire logic mgmtTxDone,
    input wire logic phyReadDone,
    input wire logic pktValid,
    input wire logic pktIsMgmt,
    input wire logic pktPassFilter,
    input wire logic pktTypeII,
    input wire logic pktLast,
    input wire logic [`MOS_DATA_W-1:0] pktData,
    output logic pktReady,
    input wire logic reclaimDone,
    input wire logic ctrlReady,
    output logic [`MOS_DATA_W-1:0] ctrlData,
    output logic ctrlValid,
    output logic mgmtAlertLine_n,
    output logic mgmtRequestFlag,
    output logic forcedMgmtMode,
    output logic txSuspend,
    output logic rxSuspend,
    output logic abortTraffic,
    output logic hostBusIgnore,
    output logic txAccept,
    output logic reclaimStart,
    output logic wakeMatchStop,
    output logic pmEvent,
    output logic cfgStrobe,
    output logic [`MOS_CFG_W-1:0] cfgKind,
    output logic phyAccess,
    output logic [`MOS_PWR_W-1:0] statusPower,
    output logic statusLink,
    output logic [`MOS_CNT_W-1:0] rxMgmtCount,
    output logic [`MOS_CNT_W-1:0] txMgmtCount,
    output logic [`MOS_CNT_W-1:0] rxNormCount,
    output logic [`MOS_CNT_W-1:0] txNormCount
);
    mos_state_type state_r, state_nxt;
    logic rxEn_r, rxEn_nxt, forced_r, forced_nxt, alert_r, alert_nxt;
    logic flag_r, flag_nxt, abort_r, abort_nxt, txAcc_r, txAcc_nxt;
    logic recl_r, recl_nxt, stopWake_r, stopWake_nxt, pme_r, pme_nxt;
    logic cfgS_r, cfgS_nxt, phy_r, phy_nxt, last_r, last_nxt;
    logic [`MOS_CFG_W-1:0] cfgK_r, cfgK_nxt;
    logic [`MOS_PWR_W-1:0] pwr_r;
    logic link_r;
    logic [`MOS_CNT_W-1:0] rxM_r, rxM_nxt, txM_r, txM_nxt, rxN_r, rxN_nxt, txN_r, txN_nxt;
    logic fifoInReady, fifoValid;
    logic [`MOS_DATA_W-1:0] fifoData;
    logic lowPower, eligible, takeByte, pktEnd, fwdPkt, ctrlV_r;
    logic [`MOS_DATA_W-1:0] ctrlD_r;

    assign lowPower = (powerState != `MOS_PWR_D0);
    assign eligible = rxAllFiltered ? pktPassFilter : (pktIsMgmt && pktTypeII);
    assign fwdPkt = rxEn_r && eligible;
    assign takeByte = pktValid && pktReady;
    assign pktEnd = takeByte && pktLast;

    // Back-pressure on the packet source comes from the buffer
    mos_fifo #(.WIDTH(`MOS_DATA_W), .DEPTH(`MOS_FIFO_DEPTH)) uFifo (
        .sys_clk(sys_clk),
        .rst(rst),
        .flush(abort_r),
        .inData(pktData),
        .inValid(pktValid && fwdPkt && state_r == MOS_RXSEND),
        .inReady(fifoInReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(ctrlReady || !ctrlV_r)
    );

    always_comb begin
        state_nxt = state_r;
        rxEn_nxt = rxEn_r;
        forced_nxt = forced_r;
        alert_nxt = alert_r;
        flag_nxt = flag_r;
        abort_nxt = 1'b0;
        txAcc_nxt = 1'b0;
        recl_nxt = 1'b0;
        stopWake_nxt = 1'b0;
        pme_nxt = 1'b0;
        cfgS_nxt = 1'b0;
        cfgK_nxt = cfgK_r;
        phy_nxt = 1'b0;
        last_nxt = last_r;
        rxM_nxt = rxM_r;
        txM_nxt = txM_r;
        rxN_nxt = rxN_r;
        txN_nxt = txN_r;
        if (alertAck) begin
            alert_nxt = 1'b0;
        end
        if (powerState != pwr_r || linkUp != link_r) begin
            alert_nxt = 1'b1;
        end
        if (phyReadDone) begin
            alert_nxt = 1'b1;
        end
        if (pktEnd && pktIsMgmt) begin
            rxM_nxt = rxM_r + `MOS_ONE;
            if (forced_r) begin
                rxN_nxt = rxN_r + `MOS_ONE;
            end
            if (lowPower) begin
                stopWake_nxt = 1'b1;
            end
            if (lowPower && !rxEn_r && wakeOnMgmt) begin
                pme_nxt = 1'b1;
            end
        end
        if (cmdValid && cmdCode == `MOS_CMD_RXEN) begin
            rxEn_nxt = 1'b1;
        end
        if (cmdValid && cmdCode == `MOS_CMD_RXDIS) begin
            rxEn_nxt = 1'b0;
        end
        if (forced_r && cmdValid && cmdCode == `MOS_CMD_CFG) begin
            cfgS_nxt = 1'b1;
            cfgK_nxt = cfgSel;
        end
        if (cmdValid && (cmdCode == `MOS_CMD_PHYWR ? forced_r : cmdCode == `MOS_CMD_PHYRD)
            && (forced_r || lowPower)) begin
            phy_nxt = 1'b1;
        end
        unique case (state_r)
            MOS_IDLE: begin
                // command only when no alert exchange pending
                if (cmdValid && cmdCode == `MOS_CMD_XMIT && !alert_r) begin
                    state_nxt = MOS_TXWAIT;
                end else if (pktValid && fwdPkt && !alert_r) begin
                    flag_nxt = 1'b1;
                    state_nxt = MOS_RXSEND;
                end
            end
            MOS_TXWAIT: begin
                if (!txDmaBusy) begin
                    flag_nxt = 1'b1;
                    txAcc_nxt = 1'b1;
                    state_nxt = MOS_TXRUN;
                end
            end
            MOS_TXRUN: begin
                if (mgmtTxDmaDone) begin
                    txM_nxt = txM_r + `MOS_ONE;
                end
                if (mgmtTxDone) begin
                    txN_nxt = txN_r + `MOS_ONE;
                    flag_nxt = 1'b0;
                    state_nxt = MOS_IDLE;
                end
            end
            MOS_RXSEND: begin
                if (pktEnd) begin
                    last_nxt = 1'b1;
                end
                if ((last_r || pktEnd) && !fifoValid && !ctrlV_r) begin
                    last_nxt = 1'b0;
                    recl_nxt = 1'b1;
                    alert_nxt = 1'b1;
                    state_nxt = MOS_RXRECL;
                end
            end
            MOS_RXRECL: begin
                if (reclaimDone) begin
                    flag_nxt = 1'b0;
                    state_nxt = MOS_IDLE;
                end
            end
            default: begin
                state_nxt = MOS_IDLE;
            end
        endcase
        // abort on forced entry
        // Placed after the sequence so it cancels any service in flight
        if (cmdValid && cmdCode == `MOS_CMD_FORCE && !forced_r) begin
            forced_nxt = 1'b1;
            abort_nxt = 1'b1;
            flag_nxt = 1'b0;
            txAcc_nxt = 1'b0;
            recl_nxt = 1'b0;
            last_nxt = 1'b0;
            state_nxt = MOS_IDLE;
        end
        // forced mode left only on reset inputs
        if (hostBusReset || !alternateResetInput_n) begin
            forced_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_r <= MOS_IDLE;
            rxEn_r <= 1'b0;
            forced_r <= 1'b0;
            alert_r <= 1'b0;
            flag_r <= 1'b0;
            abort_r <= 1'b0;
            txAcc_r <= 1'b0;
            recl_r <= 1'b0;
            stopWake_r <= 1'b0;
            pme_r <= 1'b0;
            cfgS_r <= 1'b0;
            cfgK_r <= `MOS_CFG_LINK;
            phy_r <= 1'b0;
            last_r <= 1'b0;
            pwr_r <= `MOS_PWR_D0;
            link_r <= 1'b0;
            rxM_r <= '0;
            txM_r <= '0;
            rxN_r <= '0;
            txN_r <= '0;
        end else begin
            state_r <= state_nxt;
            rxEn_r <= rxEn_nxt;
            forced_r <= forced_nxt;
            alert_r <= alert_nxt;
            flag_r <= flag_nxt;
            abort_r <= abort_nxt;
            txAcc_r <= txAcc_nxt;
            recl_r <= recl_nxt;
            stopWake_r <= stopWake_nxt;
            pme_r <= pme_nxt;
            cfgS_r <= cfgS_nxt;
            cfgK_r <= cfgK_nxt;
            phy_r <= phy_nxt;
            last_r <= last_nxt;
            pwr_r <= powerState;
            link_r <= linkUp;
            rxM_r <= rxM_nxt;
            txM_r <= txM_nxt;
            rxN_r <= rxN_nxt;
            txN_r <= txN_nxt;
        end
    end

    // Output stage to the controller, one word skid
    always_ff @(posedge sys_clk) begin
        if (rst || abort_r) begin
            ctrlV_r <= 1'b0;
            ctrlD_r <= '0;
        end else if (ctrlReady || !ctrlV_r) begin
            ctrlV_r <= fifoValid;
            ctrlD_r <= fifoData;
        end
    end

    // Packet source waits when the buffer fills in send, or in idle for a forwardable packet
    // Forwardable packet held in idle, else its first byte is lost
    assign pktReady = (state_r == MOS_RXSEND) ? fifoInReady : !(state_r == MOS_IDLE && fwdPkt);
    assign ctrlData = ctrlD_r;
    assign ctrlValid = ctrlV_r;
    assign mgmtAlertLine_n = !alert_r;
    assign mgmtRequestFlag = flag_r;
    assign forcedMgmtMode = forced_r;
    // receive suspended only for packet service
    assign rxSuspend = (state_r == MOS_RXSEND) || (state_r == MOS_RXRECL);
    assign txSuspend = flag_r;
    assign abortTraffic = abort_r;
    assign hostBusIgnore = forced_r;
    assign txAccept = txAcc_r;
    assign reclaimStart = recl_r;
    assign wakeMatchStop = stopWake_r;
    assign pmEvent = pme_r;
    assign cfgStrobe = cfgS_r;
    assign cfgKind = cfgK_r;
    assign phyAccess = phy_r;
    assign statusPower = pwr_r;
    assign statusLink = link_r;
    assign rxMgmtCount = rxM_r;
    assign txMgmtCount = txM_r;
    assign rxNormCount = rxN_r;
    assign txNormCount = txN_r;
endmodule : mos_sequencer

// File: dv/mos_ctrl_model.sv
// Purpose: management controller model on the far side
// Assumes: one clock, sync reset
// Notes: collects bytes, answers alerts after three cycles
`timescale 1ns/10ps
`include "mos_regs.svh"
module mos_ctrl_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic stall,
    input wire logic [`MOS_DATA_W-1:0] ctrlData,
    input wire logic ctrlValid,
    output logic ctrlReady,
    input wire logic mgmtAlertLine_n,
    output logic alertAck
);
    logic [`MOS_DATA_W-1:0] got[$];
    int waitCnt = 0;
    initial ctrlReady = 1'b0;
    initial alertAck = 1'b0;
    always @(negedge sys_clk) begin
        ctrlReady <= !stall && !rst;
        alertAck <= 1'b0;
        if (!rst && mgmtAlertLine_n === 1'b0 && !alertAck) begin
            waitCnt <= (waitCnt == 3) ? 0 : waitCnt + 1;
            alertAck <= (waitCnt == 3);
        end
    end
    always @(posedge sys_clk) begin
        if (ctrlValid && ctrlReady) got.push_back(ctrlData);
    end
endmodule : mos_ctrl_model

// File: dv/mos_sequencer_chk.sv
// Purpose: port assertions of the sequencer
// Assumes: one clock, sync reset
// Notes: bound below the module
`timescale 1ns/10ps
`include "mos_regs.svh"
module mos_sequencer_chk (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hostBusReset,
    input wire logic alternateResetInput_n,
    input wire logic [`MOS_CMD_W-1:0] cmdCode,
    input wire logic cmdValid,
    input wire logic [`MOS_CFG_W-1:0] cfgSel,
    input wire logic txDmaBusy,
    input wire logic mgmtTxDmaDone,
    input wire logic phyReadDone,
    input wire logic pktValid,
    input wire logic pktIsMgmt,
    input wire logic pktLast,
    input wire logic pktReady,
    input wire logic mgmtAlertLine_n,
    input wire logic mgmtRequestFlag,
    input wire logic forcedMgmtMode,
    input wire logic abortTraffic,
    input wire logic txSuspend,
    input wire logic rxSuspend,
    input wire logic hostBusIgnore,
    input wire logic txAccept,
    input wire logic reclaimStart,
    input wire logic cfgStrobe,
    input wire logic [`MOS_CFG_W-1:0] cfgKind,
    input wire logic statusLink,
    input wire logic [`MOS_CNT_W-1:0] rxMgmtCount,
    input wire logic [`MOS_CNT_W-1:0] txMgmtCount
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic calm;
    assign calm = !hostBusReset && alternateResetInput_n;
    a_force_entry: assert property (cmdValid && cmdCode == `MOS_CMD_FORCE && calm
        && !forcedMgmtMode |=> forcedMgmtMode && abortTraffic) else $error("force entry");
    a_host_ignore: assert property (hostBusIgnore == forcedMgmtMode)
        else $error("host ignore");
    a_force_hold: assert property (forcedMgmtMode && calm |=> forcedMgmtMode)
        else $error("forced lost");
    a_dma_first: assert property (txAccept |-> !$past(txDmaBusy) && mgmtRequestFlag)
        else $error("accept early");
    a_txdma_count: assert property (mgmtTxDmaDone && txSuspend && !rxSuspend
        |=> txMgmtCount == $past(txMgmtCount) + `MOS_ONE) else $error("tx count");
    a_rx_count: assert property (pktValid && pktReady && pktLast && pktIsMgmt
        |=> rxMgmtCount == $past(rxMgmtCount) + `MOS_ONE) else $error("rx count");
    a_rx_flag: assert property (rxSuspend |-> mgmtRequestFlag)
        else $error("flag off");
    a_phy_alert: assert property (phyReadDone |=> !mgmtAlertLine_n)
        else $error("phy alert");
    a_cfg_kind: assert property (cmdValid && cmdCode == `MOS_CMD_CFG && forcedMgmtMode
        && calm |=> cfgStrobe && cfgKind == $past(cfgSel)) else $error("cfg kind");
    a_link_alert: assert property ($changed(statusLink) |-> ##[0:1] !mgmtAlertLine_n)
        else $error("link alert");
    c_tx: cover property (txAccept);
    c_reclaim: cover property (reclaimStart);
    c_cfg: cover property (cfgStrobe);
endmodule : mos_sequencer_chk
bind mos_sequencer mos_sequencer_chk i_mos_sequencer_chk (.*);

// File: dv/mos_sequencer_tb_top.sv
// Purpose: directed bench of the sequencer
// Assumes: inputs change on the falling edge
// Notes: hangs end at the cycle ceiling
`timescale 1ns/10ps
`include "mos_regs.svh"
module mos_sequencer_tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, hostBusReset = 1'b0, alternateResetInput_n = 1'b1;
    logic cmdValid = 1'b0, rxAllFiltered = 1'b0, wakeOnMgmt = 1'b0, linkUp = 1'b0;
    logic txDmaBusy = 1'b0, mgmtTxDmaDone = 1'b0, mgmtTxDone = 1'b0, phyReadDone = 1'b0;
    logic pktValid = 1'b0, pktIsMgmt = 1'b1, pktPassFilter = 1'b1, pktTypeII = 1'b1;
    logic pktLast = 1'b0, reclaimDone = 1'b0, stall = 1'b0;
    logic [`MOS_CMD_W-1:0] cmdCode = `MOS_CMD_NONE;
    logic [`MOS_CFG_W-1:0] cfgSel = 2'h0, cfgKind;
    logic [`MOS_PWR_W-1:0] powerState = `MOS_PWR_D0, statusPower;
    logic [`MOS_DATA_W-1:0] pktData = 8'h00, ctrlData;
    logic [`MOS_CNT_W-1:0] rxMgmtCount, txMgmtCount, rxNormCount, txNormCount, base;
    logic alertAck, pktReady, ctrlReady, ctrlValid, mgmtAlertLine_n, mgmtRequestFlag;
    logic forcedMgmtMode, txSuspend, rxSuspend, abortTraffic, hostBusIgnore, txAccept;
    logic reclaimStart, wakeMatchStop, pmEvent, cfgStrobe, phyAccess, statusLink;
    int errTotal = 0, checksDone = 0, cycles = 0;
    mos_sequencer i_mos_sequencer (.*);
    mos_ctrl_model i_mos_ctrl_model (.*);
    initial forever #4 sys_clk = ~sys_clk;
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checksDone++;
        if (seen !== exp) begin
            errTotal++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task print_verdict();
        if (errTotal == 0 && checksDone > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // Hang guard, runs need under two hundred cycles
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            errTotal++;
            print_verdict();
        end
    end
    task cmd(input logic [`MOS_CMD_W-1:0] c);
        @(negedge sys_clk);
        cmdCode = c;
        cmdValid = 1'b1;
        @(negedge sys_clk);
        cmdValid = 1'b0;
    endtask : cmd
    task automatic pulse(ref logic s);
        @(negedge sys_clk);
        s = 1'b1;
        @(negedge sys_clk);
        s = 1'b0;
    endtask : pulse
    task wait_alert(input logic lvl);
        while (mgmtAlertLine_n !== lvl) @(negedge sys_clk);
    endtask : wait_alert
    // Bytes wait for room, controller stall lifted after four refusals
    task send_pkt(input int n, output int stalls);
        stalls = 0;
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            pktValid = 1'b1;
            pktData = 8'h40 + i[7:0];
            pktLast = (i == n - 1);
            while (pktReady !== 1'b1) begin
                stalls++;
                if (stalls == 4) stall = 1'b0;
                @(negedge sys_clk);
            end
        end
        @(negedge sys_clk);
        pktValid = 1'b0;
        pktLast = 1'b0;
    endtask : send_pkt
    task t_tx();
        txDmaBusy = 1'b1;
        cmd(`MOS_CMD_XMIT);
        repeat (3) @(negedge sys_clk);
        chk(mgmtRequestFlag, 1'b0);
        txDmaBusy = 1'b0;
        while (txAccept !== 1'b1) @(negedge sys_clk);
        chk(mgmtRequestFlag, 1'b1);
        chk(pktReady, 1'b1);
        pulse(mgmtTxDmaDone);
        chk(txMgmtCount, 16'h0001);
        pulse(mgmtTxDone);
        chk(txNormCount, 16'h0001);
        chk(mgmtRequestFlag, 1'b0);
    endtask : t_tx
    task t_rx();
        int stalls;
        cmd(`MOS_CMD_RXEN);
        stall = 1'b1;
        send_pkt(20, stalls);
        chk(16'(stalls >= 4), 16'h0001);
        while (reclaimStart !== 1'b1) @(negedge sys_clk);
        chk(16'(i_mos_ctrl_model.got.size()), 16'h0014);
        chk(rxMgmtCount, 16'h0001);
        for (int i = 0; i < 20; i++) chk(i_mos_ctrl_model.got[i], 8'h40 + i[7:0]);
        pulse(reclaimDone);
        chk(mgmtRequestFlag, 1'b0);
        wait_alert(1'b1);
    endtask : t_rx
    task t_lowpow();
        int stalls;
        powerState = 2'h1;
        wait_alert(1'b0);
        chk(statusPower, 16'h0001);
        wait_alert(1'b1);
        cmd(`MOS_CMD_RXDIS);
        wakeOnMgmt = 1'b1;
        send_pkt(1, stalls);
        chk(pmEvent, 1'b1);
        chk(wakeMatchStop, 1'b1);
        chk(rxMgmtCount, 16'h0002);
        wakeOnMgmt = 1'b0;
        powerState = `MOS_PWR_D0;
        wait_alert(1'b0);
        wait_alert(1'b1);
    endtask : t_lowpow
    // forced mode as an emergency only
    task t_force();
        int stalls;
        for (int k = 0; k < 2; k++) begin
            cmd(`MOS_CMD_FORCE);
            chk(abortTraffic, 1'b1);
            chk(hostBusIgnore, 1'b1);
            for (int c = 0; c < 4; c++) begin
                cfgSel = c[1:0];
                cmd(`MOS_CMD_CFG);
                chk(cfgKind, c[1:0]);
                chk(cfgStrobe, 1'b1);
            end
            cmd(`MOS_CMD_PHYWR);
            chk(phyAccess, 1'b1);
            pulse(phyReadDone);
            chk(mgmtAlertLine_n, 1'b0);
            wait_alert(1'b1);
            if (k == 1) begin
                base = rxNormCount;
                cmd(`MOS_CMD_RXEN);
                send_pkt(2, stalls);
                chk(rxNormCount, base + 16'h0001);
                while (reclaimStart !== 1'b1) @(negedge sys_clk);
                pulse(reclaimDone);
                wait_alert(1'b1);
                alternateResetInput_n = 1'b0;
            end
            pulse(hostBusReset);
            alternateResetInput_n = 1'b1;
            chk(forcedMgmtMode, 1'b0);
        end
        cmd(`MOS_CMD_CFG);
        chk(cfgStrobe, 1'b0);
    endtask : t_force
    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        chk(mgmtAlertLine_n, 1'b1);
        t_tx();
        linkUp = 1'b1;
        wait_alert(1'b0);
        chk(statusLink, 1'b1);
        wait_alert(1'b1);
        t_rx();
        t_lowpow();
        t_force();
        print_verdict();
    end
endmodule : mos_sequencer_tb_top
